// ==== rtl/ltx_top.sv ====
// Transmit path configuration registers with per-channel sampler, FIFO and encoder
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ltx_top (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // Wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [ltx_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // Framer side
  input  wire logic [ltx_pkg::CH_N-1:0]     tx_line_clock,
  input  wire logic [ltx_pkg::CH_N-1:0]     tx_single_rail_in,
  input  wire logic [2*ltx_pkg::CH_N-1:0]   tx_dual_rail_in,
  output logic      [ltx_pkg::CH_N-1:0]     tx_accept,
  // Line side
  input  wire logic [ltx_pkg::CH_N-1:0]     line_ready,
  output logic      [ltx_pkg::CH_N-1:0]     line_pos,
  output logic      [ltx_pkg::CH_N-1:0]     line_neg,
  output logic      [ltx_pkg::CH_N-1:0]     line_valid,
  output logic      [ltx_pkg::CH_N-1:0]     line_drive_en,
  // Driver monitor
  input  wire logic [ltx_pkg::CH_N-1:0]     driver_fail_sense,
  output logic      [ltx_pkg::CH_N-1:0]     driver_fail_monitor,
  // Waveform shaper
  output logic      [4*ltx_pkg::CH_N-1:0]   pulse_template_select,
  output logic      [ltx_pkg::CH_N-1:0]     template_user,
  output logic                              global_line_standard
);
  import ltx_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  localparam int IDX_W = ADR_W - 2;
  localparam int CH_W  = IDX_W - CH_LSB;

  logic [7:0] ctrl_q [CH_N];
  logic [7:0] tmpl_q [CH_N];
  logic [7:0] glb_q;
  logic [CH_N-1:0] fail_q;
  logic            ack_q;
  logic [31:0]     rd_q;

  wire [IDX_W-1:0]  idx    = wb_adr_i[ADR_W-1:2];
  wire [CH_W-1:0]   ch_sel = idx[IDX_W-1:CH_LSB];
  wire [CH_LSB-1:0] off    = idx[CH_LSB-1:0];
  wire req     = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr_en   = req && wb_we_i && wb_sel_i[0];
  wire is_ctrl = (off == IDX_CTRL);
  wire is_tmpl = (off == IDX_TMPL);
  wire is_glob = (idx == IDX_GLOBAL);
  wire is_stat = (idx == IDX_STATUS);
  wire copy_on = glb_q[GLB_COPY];
  wire [7:0] wr_byte = wb_dat_i[7:0];

  wire [7:0] rd_mux = is_glob ? glb_q :
                      is_stat ? fail_q :
                      is_ctrl ? ctrl_q[ch_sel] :
                      is_tmpl ? tmpl_q[ch_sel] : 8'h00;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign global_line_standard = glb_q[GLB_STD];

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: answers every access one cycle after the request

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rd_q  <= '0;
    end else begin
      ack_q <= req;
      if (req) begin
        rd_q <= {24'h000000, rd_mux};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      glb_q <= GLB_RST;
    end else if (wr_en && is_glob) begin
      glb_q <= wr_byte & GLB_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel registers and data path

  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    ltx_fifo_if #(.W(2)) fq ();
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic       clk_d_q;

    // Writes land here on a channel hit or in broadcast mode
    wire hit    = wr_en && !is_glob && !is_stat
                  && (ch_sel == CH_W'(c) || copy_on);
    wire pwrdn  = ctrl_q[c][CTRL_PWRDN];
    wire pol    = ctrl_q[c][CTRL_POL];
    wire edge_r = ctrl_q[c][CTRL_EDGE];
    wire [1:0] mode = ctrl_q[c][1:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_q[c] <= CTRL_RST;
      end else if (hit && is_ctrl) begin
        ctrl_q[c] <= wr_byte & CTRL_MASK;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        tmpl_q[c] <= TMPL_RST;
      end else if (hit && is_tmpl) begin
        tmpl_q[c] <= wr_byte & TMPL_MASK;
      end
    end

    // Two-flop synchronisers for clock, data and fault sense
    wire [4:0] raw = {driver_fail_sense[c], tx_dual_rail_in[2*c+1],
                      tx_dual_rail_in[2*c], tx_single_rail_in[c], tx_line_clock[c]};

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q    <= '0;
        s2_q    <= '0;
        clk_d_q <= 1'b0;
      end else begin
        s1_q    <= raw;
        s2_q    <= s1_q;
        clk_d_q <= s2_q[0];
      end
    end

    wire rise = s2_q[0] && !clk_d_q;
    wire fall = !s2_q[0] && clk_d_q;
    wire take = edge_r ? rise : fall;

    // Polarity applies to both input forms
    assign fq.in_valid = take && !pwrdn;
    assign fq.in_data  = mode[CTRL_MODE_HI] ? {s2_q[3] ^ pol, s2_q[2] ^ pol}
                                            : {s2_q[1] ^ pol, 1'b0};
    assign tx_accept[c] = fq.in_ready && !pwrdn;

    ltx_fifo #(.W(2), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .f       (fq)
    );

    ltx_encoder u_enc (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .f           (fq),
      .coding_mode (mode),
      .line_std    (glb_q[GLB_STD]),
      .pwrdn       (pwrdn),
      .line_ready  (line_ready[c]),
      .line_pos    (line_pos[c]),
      .line_neg    (line_neg[c]),
      .line_valid  (line_valid[c])
    );

    // Driver off in power-down or high impedance; path runs on in the latter
    assign line_drive_en[c] = !pwrdn && !tmpl_q[c][TMPL_HIZ];

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        fail_q[c] <= 1'b0;
      end else begin
        fail_q[c] <= s2_q[4] && !tmpl_q[c][TMPL_DFM_DIS] && line_drive_en[c];
      end
    end

    assign driver_fail_monitor[c] = fail_q[c];
    assign pulse_template_select[4*c +: 4] = tmpl_q[c][3:0];
    assign template_user[c] = (tmpl_q[c][3:2] == TMPL_USER);

    // Checks for the channel
    drive_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pwrdn || tmpl_q[c][TMPL_HIZ]) |-> !line_drive_en[c])
      else $error("Line driver enabled while off");
    hiz_runs_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tmpl_q[c][TMPL_HIZ] && !pwrdn && take |-> fq.in_valid)
      else $error("High impedance stopped the path");
    edge_pick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fq.in_valid |-> (edge_r ? (s2_q[0] && !clk_d_q) : (!s2_q[0] && clk_d_q)))
      else $error("Data sampled on the wrong edge");
    polarity_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fq.in_valid && !mode[CTRL_MODE_HI] |-> fq.in_data[1] == (s2_q[1] ^ pol))
      else $error("Single-rail polarity wrong");
    monitor_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tmpl_q[c][TMPL_DFM_DIS] |=> !driver_fail_monitor[c])
      else $error("Failure monitor active while disabled");
    broadcast_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_en && is_ctrl && copy_on && !is_glob && !is_stat
        |=> ctrl_q[c] == ($past(wr_byte) & CTRL_MASK))
      else $error("Broadcast write missed a channel");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus checks

  sequence wb_request;
    wb_cyc_i && wb_stb_i && !ack_q;
  endsequence

  sequence wb_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  wb_ack_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wb_request |=> wb_answer)
    else $error("Bus answer not one cycle long");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("Upper data bits not zero");
  ctrl_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wb_request ##0 (!wb_we_i && is_ctrl && !is_glob && !is_stat)
      |=> wb_dat_o[7:5] == 3'h0)
    else $error("Reserved path bits read nonzero");
endmodule
`default_nettype wire

// ==== rtl/ltx_pkg.sv ====
// Constants and types for the per-channel transmit path configuration block
// How it works
// - Each of the eight channels owns both transmit registers, channel copies 20H apart from 02H/03H.
// - Power-down bit 4 of the path register stops the transmitter and turns the line driver off.
// - Polarity bit 3 treats single-rail and dual-rail input data as active high at 0, active low at 1.
// - Edge bit 2 samples input data on falling clock edges at 0 and on rising edges at 1.
// - Coding mode 00 takes single-rail data and applies HDB3 (E1) or B8ZS (T1/J1) substitution.
// - Coding mode 01 takes single-rail data and applies plain AMI with no zero substitution.
// - Upper coding mode bit 1 bypasses the encoder and forwards the framer's dual-rail data.
// - Bit 5 of the driver register keeps the driver failure monitor on at 0 while the line driver is enabled, off at 1; reset 0.
// - Bit 4 of the driver register (reset 1) turns only the line driver and its failure monitor off; the path keeps running.
// - The 4-bit template field picks E1, T1 cable ranges, J1, reserved or user waveform shapes.
// - One global bit selects E1 at 0 and T1/J1 at 1, steering the substitution code.
// - With the global broadcast bit set, a write to one channel's register lands in every channel.
package ltx_pkg;
  localparam int CH_N   = 8;
  localparam int ADR_W  = 10;
  localparam int CH_LSB = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int SUB_LEN    = 8;
  localparam int HDB_LEN    = 4;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL   = 5'h02;
  localparam logic [4:0] IDX_TMPL   = 5'h03;
  localparam logic [7:0] IDX_STATUS = 8'h1e;
  localparam logic [7:0] IDX_GLOBAL = 8'h1f;
  // Path control fields
  localparam int CTRL_PWRDN = 4;
  localparam int CTRL_POL   = 3;
  localparam int CTRL_EDGE  = 2;
  localparam int CTRL_MODE_HI = 1;
  localparam logic [7:0] CTRL_MASK = 8'h1f;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  // Driver and template fields
  localparam int TMPL_DFM_DIS = 5;
  localparam int TMPL_HIZ     = 4;
  localparam logic [7:0] TMPL_MASK = 8'h3f;
  localparam logic [7:0] TMPL_RST  = 8'h10;
  localparam logic [1:0] TMPL_USER = 2'h3;
  // Global fields
  localparam int GLB_STD  = 4;
  localparam int GLB_COPY = 3;
  localparam logic [7:0] GLB_MASK = 8'h18;
  localparam logic [7:0] GLB_RST  = 8'h00;
  // Coding modes
  localparam logic [1:0] MODE_SUBST = 2'h0;
  localparam logic [1:0] MODE_AMI   = 2'h1;
  typedef enum logic [1:0] {SYM_ZERO, SYM_MARK, SYM_VIOL, SYM_BAL} ltx_sym_t;
endpackage

// ==== rtl/ltx_fifo_if.sv ====
// Stream carrier between the sampler, the FIFO and the encoder
`timescale 1ns/1ps
`default_nettype none
interface ltx_fifo_if #(parameter int W = 2);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport src  (output in_valid, output in_data, input in_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
  modport snk  (input out_valid, input out_data, output out_ready);
endinterface
`default_nettype wire

// ==== rtl/ltx_fifo.sv ====
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ltx_fifo #(
  parameter int W     = 2,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Stream
  ltx_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic [W-1:0] mem [DEPTH];
  wire full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push  = f.in_valid && !full;
  wire pop   = f.out_ready && !empty;
  assign f.in_ready  = !full;
  assign f.out_valid = !empty;
  assign f.out_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= f.in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  full_hold_a: assert property (full && f.in_valid && !pop |=> full && $stable(wp_q))
    else $error("FIFO accepted a word while full");
endmodule
`default_nettype wire

// ==== rtl/ltx_encoder.sv ====
// Line encoder: HDB3/B8ZS, AMI or dual-rail bypass
`timescale 1ns/1ps
`default_nettype none
module ltx_encoder
  import ltx_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Stream in
  ltx_fifo_if.snk        f,
  // Configuration
  input wire logic [1:0] coding_mode,
  input wire logic       line_std,
  input wire logic       pwrdn,
  // Line side
  input wire logic       line_ready,
  output logic           line_pos,
  output logic           line_neg,
  output logic           line_valid
);
  ltx_sym_t sym_q [SUB_LEN];
  ltx_sym_t sh    [SUB_LEN];
  logic     odd_q;
  logic     last_q;
  logic     subst_hit;
  wire pop    = f.out_valid && f.out_ready;
  wire bypass = coding_mode[CTRL_MODE_HI];
  wire subst  = (coding_mode == MODE_SUBST);
  wire oldest_nz = (sym_q[SUB_LEN-1] != SYM_ZERO);
  wire new_pol   = (sym_q[SUB_LEN-1] == SYM_VIOL) ? last_q : !last_q;
  assign f.out_ready = line_ready && !pwrdn;

  always_comb begin
    logic b8_zero;
    logic hd_zero;
    b8_zero = 1'b1;
    hd_zero = 1'b1;
    sh[0] = f.out_data[1] ? SYM_MARK : SYM_ZERO;
    for (int i = 1; i < SUB_LEN; i++) begin
      sh[i] = sym_q[i-1];
    end
    for (int i = 0; i < SUB_LEN; i++) begin
      b8_zero = b8_zero && (sh[i] == SYM_ZERO);
      if (i < HDB_LEN) begin
        hd_zero = hd_zero && (sh[i] == SYM_ZERO);
      end
    end
    subst_hit = 1'b0;
    if (subst && line_std && b8_zero) begin
      subst_hit = 1'b1;
      sh[4] = SYM_VIOL;
      sh[3] = SYM_BAL;
      sh[1] = SYM_VIOL;
      sh[0] = SYM_BAL;
    end else if (subst && !line_std && hd_zero) begin
      subst_hit = 1'b1;
      sh[HDB_LEN-1] = odd_q ? SYM_ZERO : SYM_BAL;
      sh[0] = SYM_VIOL;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SUB_LEN; i++) begin
        sym_q[i] <= SYM_ZERO;
      end
      odd_q      <= 1'b0;
      last_q     <= 1'b0;
      line_pos   <= 1'b0;
      line_neg   <= 1'b0;
      line_valid <= 1'b0;
    end else begin
      line_valid <= pop;
      if (pop && bypass) begin
        line_pos <= f.out_data[1];
        line_neg <= f.out_data[0];
      end else if (pop) begin
        sym_q    <= sh;
        odd_q    <= subst_hit ? 1'b0 : (odd_q ^ f.out_data[1]);
        line_pos <= oldest_nz && new_pol;
        line_neg <= oldest_nz && !new_pol;
        if (oldest_nz) begin
          last_q <= new_pol;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  bypass_pass_a: assert property (pop && bypass |=> line_valid
      && line_pos == $past(f.out_data[1]) && line_neg == $past(f.out_data[0]))
    else $error("Dual-rail data not passed through");
  ami_no_viol_a: assert property (pop && coding_mode == MODE_AMI |=> !(line_pos && line_neg)
      && sym_q[0] != SYM_VIOL)
    else $error("AMI mode produced a substitution");
  pwrdn_stop_a: assert property (pwrdn |=> !line_valid)
    else $error("Encoder ran while powered down");
endmodule
`default_nettype wire

// ==== sim/ltx_framer_model.sv ====
// Framer model driving transmit clock and data on every channel
`timescale 1ns/1ps
`default_nettype none
module ltx_framer_model (
  // Framer side
  output logic [7:0]  tx_line_clock,
  output logic [7:0]  tx_single_rail_in,
  output logic [15:0] tx_dual_rail_in
);
  initial begin
    tx_line_clock = 8'h00;
    tx_single_rail_in = 8'h00;
    tx_dual_rail_in = 16'h0000;
  end
  task automatic put(input logic p, input logic n);
    tx_single_rail_in = {8{p}};
    tx_dual_rail_in = {8{p, n}};
  endtask
  // Data moves between rise and fall, so only the chosen edge sees each bit
  task automatic send(input int cnt, input logic [31:0] p, input logic [31:0] n, input bit rise);
    int idx;
    if (rise) begin
      put(p[0], n[0]);
    end
    for (int i = 0; i < cnt; i++) begin
      tx_line_clock = 8'hff;
      #31.25;
      idx = rise ? i + 1 : i;
      if (idx < cnt) begin
        put(p[idx], n[idx]);
      end
      #31.25;
      tx_line_clock = 8'h00;
      #62.5;
    end
    // Clock stands still; data lines show the inverse of the last bit
    put(~p[cnt-1], ~n[cnt-1]);
  endtask
endmodule
`default_nettype wire

// ==== sim/ltx_top_test.sv ====
// Register and stream tests of the transmit path configuration block
`timescale 1ns/1ps
`default_nettype none
module ltx_top_test;
  import ltx_pkg::*;
  logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, global_line_standard;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, pulse_template_select, rd;
  logic [7:0]  tx_line_clock, tx_single_rail_in, tx_accept, line_ready, line_pos, line_neg;
  logic [7:0]  line_valid, line_drive_en, driver_fail_sense, driver_fail_monitor, template_user;
  logic [15:0] tx_dual_rail_in;
  logic [1:0]  sym_q[$];
  int          n_mismatch = 0;
  int          checks = 0;
  localparam logic [9:0] GLB_ADR  = {IDX_GLOBAL, 2'b00};
  localparam logic [9:0] STAT_ADR = {IDX_STATUS, 2'b00};

  ltx_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_line_clock(tx_line_clock),
    .tx_single_rail_in(tx_single_rail_in), .tx_dual_rail_in(tx_dual_rail_in),
    .tx_accept(tx_accept), .line_ready(line_ready), .line_pos(line_pos), .line_neg(line_neg),
    .line_valid(line_valid), .line_drive_en(line_drive_en), .driver_fail_sense(driver_fail_sense),
    .driver_fail_monitor(driver_fail_monitor), .pulse_template_select(pulse_template_select),
    .template_user(template_user), .global_line_standard(global_line_standard));
  ltx_framer_model frm_u (.tx_line_clock(tx_line_clock), .tx_single_rail_in(tx_single_rail_in),
    .tx_dual_rail_in(tx_dual_rail_in));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Channel 0 symbol monitor
  always @(posedge ref_clk) begin
    if (line_valid[0] === 1'b1) begin
      sym_q.push_back({line_pos[0], line_neg[0]});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [9:0] ra(input int ch, input logic [4:0] idx);
    ra = {ch[2:0], idx, 2'b00};
  endfunction
  task automatic wb(input logic [9:0] a, input logic we, input logic [7:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (n >= 20) begin
      chk("bus answer", 32'h0, 32'h1);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    wb(a, 1'b1, d, 4'h1);
  endtask
  task automatic rdchk(input string what, input logic [9:0] a, input logic [7:0] exp);
    wb(a, 1'b0, 8'h00, 4'h1);
    chk(what, rd, {24'h0, exp});
  endtask
  task automatic rst_pulse;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic stream(input int n, input logic [31:0] ep, input logic [31:0] en);
    int k;
    k = 0;
    while (sym_q.size() < n && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (20) @(posedge ref_clk);
    chk("symbol count", sym_q.size(), n);
    for (int i = 0; i < n && i < sym_q.size(); i++) begin
      chk("symbol", {30'h0, sym_q[i]}, {30'h0, ep[i], en[i]});
    end
    sym_q.delete();
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    n_mismatch++;
    $display("watchdog expired");
    end_of_test;
  end
  initial begin
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    line_ready = 8'hff;
    driver_fail_sense = 8'h00;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("drive enable", {24'h0, line_drive_en}, 32'h0);
    chk("accept", {24'h0, tx_accept}, 32'hff);
    chk("standard", {31'h0, global_line_standard}, 32'h0);
    for (int c = 0; c < 8; c++) begin
      rdchk("path reset", ra(c, IDX_CTRL), 8'h00);
      rdchk("driver reset", ra(c, IDX_TMPL), 8'h10);
    end
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(ra(c, IDX_CTRL), {5'h1c, c[2:0]});
      wr(ra(c, IDX_TMPL), {5'h1a, c[2:0]});
    end
    for (int c = 0; c < 8; c++) begin
      rdchk("path control", ra(c, IDX_CTRL), {5'h00, c[2:0]});
      rdchk("driver control", ra(c, IDX_TMPL), {5'h02, c[2:0]});
      chk("template", {28'h0, pulse_template_select[4*c+:4]}, {29'h0, c[2:0]});
    end
    rdchk("unmapped", 10'h000, 8'h00);
    wb(ra(1, IDX_CTRL), 1'b1, 8'h1f, 4'h0);
    rdchk("lane ignored", ra(1, IDX_CTRL), 8'h01);
    for (int t = 0; t < 16; t++) begin
      wr(ra(0, IDX_TMPL), {4'h1, t[3:0]});
      chk("template code", {28'h0, pulse_template_select[3:0]}, {28'h0, t[3:0]});
      chk("user shape", {31'h0, template_user[0]}, {31'h0, t[3:2] == 2'h3});
    end
    $display("test registers done");
    wr(GLB_ADR, 8'h18);
    chk("standard", {31'h0, global_line_standard}, 32'h1);
    wr(ra(3, IDX_CTRL), 8'h0b);
    for (int c = 0; c < 8; c++) begin
      rdchk("broadcast", ra(c, IDX_CTRL), 8'h0b);
    end
    wr(GLB_ADR, 8'h00);
    chk("standard", {31'h0, global_line_standard}, 32'h0);
    wr(ra(5, IDX_CTRL), 8'h01);
    rdchk("no broadcast", ra(4, IDX_CTRL), 8'h0b);
    rdchk("single write", ra(5, IDX_CTRL), 8'h01);
    $display("test broadcast done");
    rst_pulse;
    wr(ra(0, IDX_TMPL), 8'h00);
    chk("drive enable", {24'h0, line_drive_en}, 32'h01);
    driver_fail_sense <= 8'h03;
    repeat (6) @(posedge ref_clk);
    chk("fail monitor", {24'h0, driver_fail_monitor}, 32'h01);
    rdchk("fail status", STAT_ADR, 8'h01);
    wr(ra(0, IDX_TMPL), 8'h20);
    repeat (6) @(posedge ref_clk);
    chk("monitor off", {24'h0, driver_fail_monitor}, 32'h0);
    wr(ra(0, IDX_TMPL), 8'h00);
    wr(ra(0, IDX_CTRL), 8'h10);
    driver_fail_sense <= 8'h00;
    chk("powered down", {30'h0, line_drive_en[0], tx_accept[0]}, 32'h0);
    frm_u.send(4, 32'hf, 32'h0, 1'b0);
    stream(0, 32'h0, 32'h0);
    $display("test driver done");
    wr(ra(0, IDX_TMPL), 8'h10);
    wr(ra(0, IDX_CTRL), 8'h02);
    line_ready <= 8'hfe;
    frm_u.send(20, 32'h924924, 32'h249249, 1'b0);
    chk("full refuses", {30'h0, tx_accept[0], line_drive_en[0]}, 32'h0);
    @(posedge ref_clk);
    line_ready <= 8'hff;
    stream(16, 32'h924924, 32'h249249);
    wr(ra(0, IDX_CTRL), 8'h0e);
    frm_u.send(6, 32'h924924, 32'h249249, 1'b1);
    stream(6, ~32'h924924, ~32'h249249);
    $display("test dual rail done");
    rst_pulse;
    wr(ra(0, IDX_CTRL), 8'h01);
    frm_u.send(17, 32'h10d, 32'h0, 1'b0);
    stream(17, 32'h900, 32'h10400);
    rst_pulse;
    frm_u.send(19, 32'h61, 32'h0, 1'b0);
    stream(19, 32'h5100, 32'h4a000);
    rst_pulse;
    wr(GLB_ADR, 8'h10);
    chk("standard", {31'h0, global_line_standard}, 32'h1);
    frm_u.send(17, 32'h1, 32'h0, 1'b0);
    stream(17, 32'h11100, 32'h0a000);
    $display("test coding done");
    end_of_test;
  end
endmodule
`default_nettype wire
